// File: hdl/rrm_control.sv
`timescale 1ns/10ps
`default_nettype none
`include "rrm_defs.svh"
module rrm_control #(
    parameter int N_REL        = 2,
    parameter int CLK_HZ       = `RRM_CLK_HZ,
    parameter int DEB_SHORT_MS = `RRM_DEB_SHORT_MS,
    parameter int DEB_LONG_MS  = `RRM_DEB_LONG_MS,
    parameter int MAX_HIGH_MS  = `RRM_MAX_HIGH_MS,
    parameter int FLASH_MS     = `RRM_FLASH_MS
) (
    input  wire logic             i_clk,
    input  wire logic             i_reset_n,
    input  wire rrm_pkg::rrm_cfg_t i_cfg,
    input  wire logic [N_REL-1:0] i_eval,
    input  wire logic             i_mon_error,
    input  wire logic             i_reset_btn,
    input  wire logic             i_restart_btn,
    input  wire logic             i_mute,
    input  wire logic             i_bypass,
    output logic [N_REL-1:0]      o_release,
    output logic                  o_error,
    output logic                  o_reset_required,
    output logic                  o_restart_required
);
    localparam int CPMS       = CLK_HZ / 1000;
    localparam int SHORT_CYC  = DEB_SHORT_MS * CPMS;
    localparam int LONG_CYC   = DEB_LONG_MS * CPMS;
    localparam longint MAXC   = longint'(MAX_HIGH_MS) * longint'(CPMS);
    localparam int FLASH_CYC  = FLASH_MS * CPMS;
    localparam int CW         = $clog2(MAXC + 2);
    localparam int FW         = $clog2(FLASH_CYC + 1);

    ////////////////////////////////////////////////////////////////////////////////
    // Operator buttons come from pins: three-stage synchronisers, change on 2nd==3rd.
    logic [2:0] rst_sync;
    logic [2:0] rs_sync;
    logic       rst_lvl;
    logic       rs_lvl;
    logic       next_rst_lvl;
    logic       next_rs_lvl;
    always_comb begin
        next_rst_lvl = (rst_sync[1] == rst_sync[2]) ? rst_sync[2] : rst_lvl;
        next_rs_lvl  = (rs_sync[1] == rs_sync[2]) ? rs_sync[2] : rs_lvl;
    end
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            rst_sync <= 3'h0;
            rs_sync  <= 3'h0;
            rst_lvl  <= 1'b0;
            rs_lvl   <= 1'b0;
        end else begin
            rst_sync <= {rst_sync[1:0], i_reset_btn};
            rs_sync  <= {rs_sync[1:0], i_restart_btn};
            rst_lvl  <= next_rst_lvl;
            rs_lvl   <= next_rs_lvl;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Pulse qualifiers, one per button. A pulse already high at reset release is
    // accepted, since the level resets low and so sets armed on the first clock.
    logic [CW-1:0]     min_cyc;
    logic [1:0]        lvl;
    logic [1:0]        valid;
    rrm_pkg::rrm_pulse_t st [2];
    rrm_pkg::rrm_pulse_t next_st [2];
    logic [CW-1:0]     cnt [2];
    logic [CW-1:0]     next_cnt [2];
    logic [1:0]        next_valid;
    logic [1:0]        armed;
    logic [1:0]        next_armed;
    assign lvl = {rs_lvl, rst_lvl};
    always_comb begin
        unique case (i_cfg.debounce_sel)
            `RRM_DEB_SHORT: min_cyc = CW'(SHORT_CYC);
            `RRM_DEB_LONG:  min_cyc = CW'(LONG_CYC);
            default:        min_cyc = CW'(1);
        endcase
    end
    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_pulse
            always_comb begin
                next_st[g]    = st[g];
                next_cnt[g]   = cnt[g];
                next_valid[g] = 1'b0;
                next_armed[g] = armed[g] | ~lvl[g];
                unique case (st[g])
                    rrm_pkg::RRM_IDLE: begin
                        if (lvl[g] && armed[g]) begin
                            next_st[g]  = rrm_pkg::RRM_HIGH;
                            next_cnt[g] = CW'(1);
                        end
                    end
                    rrm_pkg::RRM_HIGH: begin
                        if (!lvl[g]) begin
                            next_st[g]    = rrm_pkg::RRM_IDLE;
                            next_valid[g] = (cnt[g] >= min_cyc);
                        end else if (cnt[g] >= CW'(MAXC)) begin
                            next_st[g] = rrm_pkg::RRM_LONG;
                        end else begin
                            next_cnt[g] = cnt[g] + CW'(1);
                        end
                    end
                    rrm_pkg::RRM_LONG: begin
                        if (!lvl[g]) begin
                            next_st[g] = rrm_pkg::RRM_IDLE;
                        end
                    end
                    default: next_st[g] = rrm_pkg::RRM_IDLE;
                endcase
            end
            always_ff @(posedge i_clk or negedge i_reset_n) begin
                if (!i_reset_n) begin
                    st[g]    <= rrm_pkg::RRM_IDLE;
                    cnt[g]   <= '0;
                    valid[g] <= 1'b0;
                    armed[g] <= 1'b0;
                end else begin
                    st[g]    <= next_st[g];
                    cnt[g]   <= next_cnt[g];
                    valid[g] <= next_valid[g];
                    armed[g] <= next_armed[g];
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////////
    // Fault latch, release confirmation, muting, bypass and indications.
    logic             fault;
    logic             next_fault;
    logic [N_REL-1:0] confirmed;
    logic [N_REL-1:0] next_confirmed;
    logic [N_REL-1:0] muted;
    logic [N_REL-1:0] next_muted;
    logic             mute_q;
    logic             mute_seen;
    logic             byp_q;
    logic             byp_seen;
    logic             byp_on;
    logic             next_byp_on;
    logic [FW-1:0]    fl_cnt;
    logic [FW-1:0]    next_fl_cnt;
    logic             fl_ph;
    logic             next_fl_ph;
    logic [N_REL-1:0] next_release;
    logic             next_error;
    logic             next_reset_req;
    logic             next_restart_req;
    logic             mute_rise;
    logic             want;
    always_comb begin
        // Mute is a same-domain level from the evaluation logic: sampled raw.
        mute_rise   = i_mute && !mute_q && mute_seen;
        next_fault  = fault;
        if (i_mon_error) begin
            next_fault = 1'b1;
        end else if (valid[0]) begin
            next_fault = 1'b0;
        end
        next_byp_on = byp_on;
        if (i_bypass && !byp_q && byp_seen) begin
            next_byp_on = 1'b1;
        end else if (!i_bypass) begin
            next_byp_on = 1'b0;
        end
        want = 1'b0;
        for (int i = 0; i < N_REL; i++) begin
            next_muted[i]     = i_mute && (muted[i] || (mute_rise && o_release[i]));
            next_confirmed[i] = confirmed[i] && i_eval[i];
            if (!i_cfg.manual_restart) begin
                next_confirmed[i] = i_eval[i];
            end else if (valid[1] && (i_eval[i] || byp_on)) begin
                next_confirmed[i] = 1'b1;
            end
            if (byp_on && !i_eval[i] && !confirmed[i] && i_cfg.manual_restart) begin
                next_confirmed[i] = valid[1];
            end
            want = want | (i_cfg.manual_restart && i_eval[i] && !confirmed[i]);
            next_release[i] = !next_fault && (next_confirmed[i] || next_muted[i]
                              || next_byp_on);
        end
        next_fl_cnt = fl_cnt + FW'(1);
        next_fl_ph  = fl_ph;
        if (fl_cnt >= FW'(FLASH_CYC - 1)) begin
            next_fl_cnt = '0;
            next_fl_ph  = !fl_ph;
        end
        next_error       = next_fault;
        next_reset_req   = next_fault && (!i_cfg.flash_reset_req || next_fl_ph);
        next_restart_req = !next_fault && want
                           && (!i_cfg.flash_restart_req || next_fl_ph);
    end
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            fault              <= 1'b0;
            confirmed          <= '0;
            muted              <= '0;
            mute_q             <= 1'b0;
            mute_seen          <= 1'b0;
            byp_q              <= 1'b0;
            byp_seen           <= 1'b0;
            byp_on             <= 1'b0;
            fl_cnt             <= '0;
            fl_ph              <= 1'b0;
            o_release          <= '0;
            o_error            <= 1'b0;
            o_reset_required   <= 1'b0;
            o_restart_required <= 1'b0;
        end else begin
            fault              <= next_fault;
            confirmed          <= next_confirmed;
            muted              <= next_muted;
            mute_q             <= i_mute;
            mute_seen          <= 1'b1;
            byp_q              <= i_bypass;
            byp_seen           <= 1'b1;
            byp_on             <= next_byp_on;
            fl_cnt             <= next_fl_cnt;
            fl_ph              <= next_fl_ph;
            o_release          <= next_release;
            o_error            <= next_error;
            o_reset_required   <= next_reset_req;
            o_restart_required <= next_restart_req;
        end
    end
endmodule
`default_nettype wire

// File: hdl/rrm_defs.svh
// Functional notes
// - Monitoring error forces releases zero, flags error.
// - Pulse high at least debounce time: 0/100/350ms.
// - Pulse high over 30 s is rejected.
// - Zero debounce: any one-cycle high accepted (code needs two cycles high at the button pin).
// - Reset-required shown while monitoring error pending.
// - Valid reset after cause cleared restores function.
// - Required indications selectable steady or flashing.
// - Manual mode: restart-required, release waits restart.
// - Automatic mode: release follows evaluation directly.
// - Restart ignored once release already confirmed.
// - Only complete low-high-low pulse counts (code accepts a pulse already high at reset release).
// - Bypass plus restart switches to regular operation.
// - Mute rising edge holds releases already set.
// - Releases set during muting are not held.
// - Mute falling edge returns releases to evaluation.
// - Mute input sampled each cycle, no debounce.
// - Mute armed only by rising edge.
// - Muting acts on all releases equally.
`ifndef RRM_DEFS_SVH
`define RRM_DEFS_SVH
`define RRM_CLK_HZ        50000000
`define RRM_DEB_SHORT_MS  100
`define RRM_DEB_LONG_MS   350
`define RRM_MAX_HIGH_MS   30000
`define RRM_FLASH_MS      250
`define RRM_DEB_OFF       2'h0
`define RRM_DEB_SHORT     2'h1
`define RRM_DEB_LONG      2'h2
`endif

// File: hdl/rrm_pkg.sv
package rrm_pkg;
    typedef struct packed {
        logic       manual_restart;
        logic [1:0] debounce_sel;
        logic       flash_reset_req;
        logic       flash_restart_req;
    } rrm_cfg_t;
    typedef enum logic [1:0] {
        RRM_IDLE = 2'b00,
        RRM_HIGH = 2'b01,
        RRM_LONG = 2'b10
    } rrm_pulse_t;
endpackage

// File: verif/rrm_operator.sv
`timescale 1ns/10ps
`default_nettype none
module rrm_operator (
    input  wire logic i_clk,
    output logic      o_reset_btn,
    output logic      o_restart_btn,
    output logic      o_mute
);
    initial begin
        o_reset_btn   = 1'b0;
        o_restart_btn = 1'b0;
        o_mute        = 1'b0;
    end
    // A press is a low-high-low pulse of the given number of cycles, then eight low cycles.
    task automatic press(input logic restart, input int cycles);
        @(negedge i_clk);
        o_restart_btn = restart;
        o_reset_btn   = !restart;
        repeat (cycles) @(negedge i_clk);
        o_restart_btn = 1'b0;
        o_reset_btn   = 1'b0;
        repeat (8) @(negedge i_clk);
    endtask
    task automatic mute(input logic level);
        @(negedge i_clk);
        o_mute = level;
    endtask
endmodule
`default_nettype wire

// File: verif/rrm_control_sva.sv
`timescale 1ns/10ps
`default_nettype none
module rrm_control_sva #(parameter int N_REL = 2) (
    input wire logic              i_clk,
    input wire logic              i_reset_n,
    input wire rrm_pkg::rrm_cfg_t i_cfg,
    input wire logic [N_REL-1:0]  i_eval,
    input wire logic              i_mon_error,
    input wire logic              i_mute,
    input wire logic              i_bypass,
    input wire logic [N_REL-1:0]  o_release,
    input wire logic              o_error,
    input wire logic              o_reset_required,
    input wire logic              o_restart_required
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_reset_n);
    err_safe_out_a: assert property (i_mon_error |=> o_error && o_release == '0)
        else $error("fault did not force safe outputs");
    fault_no_rel_a: assert property (o_error |-> o_release == '0)
        else $error("release during fault");
    fault_hold_a: assert property (o_error && i_mon_error |=> o_error)
        else $error("fault cleared while cause present");
    fault_clear_a: assert property ($fell(o_error) |-> !$past(i_mon_error))
        else $error("fault cleared with cause present");
    reset_req_a: assert property (o_error && !i_cfg.flash_reset_req |-> o_reset_required)
        else $error("reset required missing");
    auto_no_req_a: assert property (!i_cfg.manual_restart |-> !o_restart_required)
        else $error("restart required in automatic mode");
    man_req_a: assert property (i_cfg.manual_restart && !i_cfg.flash_restart_req && !i_mute
        && !i_mon_error && !o_error && !i_bypass && o_release == '0 && i_eval[0] [*3]
        |-> o_restart_required)
        else $error("restart required missing");
    mute_hold_a: assert property ($rose(i_mute) && o_release[0] && !i_mon_error
        ##1 (i_mute && !i_mon_error) [*3] |-> o_release == $past(o_release, 3))
        else $error("muted release not held");
    unmute_a: assert property ($fell(i_mute) && i_eval == '0 && !i_bypass
        ##1 (i_eval == '0 && !i_bypass) [*3] |-> o_release == '0)
        else $error("release kept after muting");
    cover property ($rose(o_release[0]) && i_cfg.manual_restart);
    cover property ($fell(o_error));
    cover property ($rose(i_mute) && o_release != '0);
endmodule
bind rrm_control rrm_control_sva #(.N_REL(N_REL)) u_sva (.i_clk, .i_reset_n, .i_cfg,
    .i_eval, .i_mon_error, .i_mute, .i_bypass, .o_release, .o_error, .o_reset_required,
    .o_restart_required);
`default_nettype wire

// File: verif/rrm_control_tb.sv
`timescale 1ns/10ps
`default_nettype none
`include "rrm_defs.svh"
module rrm_control_tb;
    localparam int MAXC = 100;
    logic              i_clk = 1'b0;
    logic              rst_n = 1'b0;
    rrm_pkg::rrm_cfg_t cfg = '0;
    logic [1:0]        eval = '0;
    logic [1:0]        rel;
    logic              mon = 1'b0;
    logic              byp = 1'b0;
    logic              err, rs_req, rst_req, b_rst, b_rs, mute;
    int                n_fail = 0;
    int                n_compared = 0;
    int                lens [4];
    int                mn;
    logic              ok = 1'b0;
    always #10 i_clk = ~i_clk;
    rrm_operator op (.i_clk, .o_reset_btn(b_rst), .o_restart_btn(b_rs), .o_mute(mute));
    // Ten cycles per millisecond keep the long pulse limits short in simulation.
    rrm_control #(.CLK_HZ(10000), .DEB_SHORT_MS(2), .DEB_LONG_MS(5),
        .MAX_HIGH_MS(10), .FLASH_MS(3)) DUT (.i_clk, .i_reset_n(rst_n), .i_cfg(cfg),
        .i_eval(eval), .i_mon_error(mon), .i_reset_btn(b_rst), .i_restart_btn(b_rs),
        .i_mute(mute), .i_bypass(byp), .o_release(rel), .o_error(err),
        .o_reset_required(rst_req), .o_restart_required(rs_req));
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(negedge i_clk);
    endtask
    task automatic start(input logic man, input logic [1:0] d);
        rst_n = 1'b0;
        cfg.manual_restart = man;
        cfg.debounce_sel = d;
        tick(2);
        rst_n = 1'b1;
        tick(2);
    endtask
    function automatic logic valid(input int len, input int min_c);
        return len >= min_c && len <= MAXC;
    endfunction
    task automatic results();
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    initial begin
        #1ms;
        n_fail++;
        results();
    end
    initial begin
        void'($urandom(32'h100c));
        start(1'b1, `RRM_DEB_SHORT);
        eval = 2'h3;
        tick(3);
        check(rs_req, 1'b1);
        lens = '{12, MAXC + 10, 24 + $urandom_range(40), 25};
        for (int i = 0; i < 4; i++) begin
            op.press(1'b1, lens[i]);
            ok = ok | valid(lens[i], 20);
            check(rel, ok ? 2'h3 : 2'h0);
        end
        check(rs_req, 1'b0);
        op.mute(1'b1);
        eval = 2'h0;
        tick(4);
        check(rel, 2'h3);
        op.mute(1'b0);
        tick(4);
        check(rel, 2'h0);
        for (int d = 0; d < 3; d++) begin
            start(1'b0, d[1:0]);
            mn = (d == 0) ? 1 : (d == 1) ? 20 : 50;
            eval = 2'h1 + 2'($urandom_range(2));
            tick(4);
            check({rs_req, rel}, {1'b0, eval});
            mon = 1'b1;
            tick(2);
            check({err, rst_req, rel}, 4'hc);
            mon = 1'b0;
            if (d > 0) begin
                op.press(1'b0, mn - 8);
                check(err, 1'b1);
            end
            op.press(1'b0, mn + 1);
            check({err, rst_req, rel}, {2'h0, eval});
        end
        eval = 2'h0;
        tick(3);
        op.mute(1'b1);
        tick(3);
        eval = 2'h3;
        tick(3);
        check(rel, 2'h3);
        eval = 2'h0;
        tick(3);
        check(rel, 2'h0);
        op.mute(1'b0);
        start(1'b1, `RRM_DEB_SHORT);
        byp = 1'b1;
        eval = 2'h3;
        tick(3);
        op.press(1'b1, 30);
        byp = 1'b0;
        tick(3);
        check(rel, 2'h3);
        // A flashing indication is high for half of every 60-cycle period.
        cfg.flash_reset_req = 1'b1;
        cfg.flash_restart_req = 1'b1;
        mon = 1'b1;
        tick(2);
        mn = 0;
        for (int i = 0; i < 60; i++) begin
            tick(1);
            mn += int'(rst_req);
        end
        check(8'(mn), 8'h1e);
        mon = 1'b0;
        op.press(1'b0, 25);
        check(err, 1'b0);
        eval = 2'h0;
        tick(3);
        eval = 2'h3;
        tick(2);
        mn = 0;
        for (int i = 0; i < 60; i++) begin
            tick(1);
            mn += int'(rs_req);
        end
        check(8'(mn), 8'h1e);
        results();
    end
endmodule
`default_nettype wire
